// ===== hdl/trig_math_map.vh
// Purpose: Constants for the trig math Type 1 datapath
// Assumes: IEEE-754 single precision operands
// Notes:   Opcode words, latencies and special result codes
`ifndef TRIG_MATH_MAP_VH
`define TRIG_MATH_MAP_VH
`define LOW_WORD_QUAD     16'hE27C
`define LOW_WORD_IEXP2    16'hE273
`define LOW_WORD_LOG2     16'hE272
`define HIGH_ZERO_MASK_1  16'hFFC0
`define HIGH_ZERO_MASK_Q  16'hF000
`define LAT_QUAD          3'h5
`define LAT_SINGLE        3'h4
`define FP_ZERO           32'h00000000
`define FP_ONE            32'h3F800000
`define FP_POS_INF        32'h7F800000
`define FP_NEG_INF        32'hFF800000
`define FP_HALF           32'h3F000000
`define FP_QUARTER        32'h3E800000
`define EXP_BIAS          8'h7F
`define EXP_MAX           8'hFF
`define SIGN_BIT          31
`define EXP_HI            30
`define EXP_LO            23
`define FIELD_A_LO        0
`define FIELD_B_LO        3
`define FIELD_C_LO        6
`define FIELD_D_LO        9
`endif

// ===== hdl/trig_math_type1_ops.v
// Purpose: Execution datapath for quadrant, inverse power-of-two and base-2 log
// Assumes: Issue stage holds ordering; register file lives here as eight words
// Notes:   Results land after fixed latency; flags are sticky until cleared
//
// Behaviour
// - The Type 1 unit keeps Type 0 opcodes intact and adds inverse power-of-two and log2.
// - Single ops take destination from field aaa and source from field bbb; quadrant writes fa and fb from fc and fd.
// - Low word E273 with zeros above the register fields selects inverse power-of-two.
// - Low word E272 with zeros above the register fields selects base-2 logarithm.
// - Quadrant touches only the latched underflow and overflow flags; log2 sets no flag.
// - Quadrant ratio special divisions give the tabled result with overflow or underflow.
// - Quadrant results reach their destinations five cycles after issue.
// - Inverse power-of-two writes two to minus the absolute source value, with fixed specials.
// - Inverse power-of-two may only set the latched underflow flag.
// - Log2 writes the base-2 log; non-positive or denormal gives -Inf, +Inf or NaN gives +Inf.
// - Inverse power-of-two and log2 results are ready four cycles after issue.
`timescale 1ns/1ps
`include "trig_math_map.vh"
`default_nettype none
module trig_math_type1_ops (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // Instruction issue
  input  wire        issue_valid,
  input  wire [15:0] low_opcode_word,
  input  wire [15:0] high_opcode_word,
  // Register file load and read port
  input  wire        load_en,
  input  wire [2:0]  load_idx,
  input  wire [31:0] load_data,
  input  wire [2:0]  read_idx,
  output reg  [31:0] read_data,
  // Flag control
  input  wire        flag_clear,
  output reg         latched_underflow_flag,
  output reg         latched_overflow_flag,
  output reg         test_flag,
  // Status
  output reg         op_recognised,
  output reg         write_done
);
  // One-hot op kinds travelling down the pipeline
  localparam [3:0]  K_NONE  = 4'h1;
  localparam [3:0]  K_IEXP  = 4'h2;
  localparam [3:0]  K_LOG   = 4'h4;
  localparam [3:0]  K_QUAD  = 4'h8;
  // Constant results as vectors so their magnitudes can be sliced
  localparam [31:0] HALF    = `FP_HALF;
  localparam [31:0] QUARTER = `FP_QUARTER;
  integer    b;
  integer    j;
  integer    k;
  reg [31:0] fp_result_reg [0:7];
  ////////////////////////////////////////////////////////////////////////////
  // Classification helpers
  function is_zero_or_den;
    input [31:0] v;
    is_zero_or_den = (v[`EXP_HI:`EXP_LO] == 8'h00);
  endfunction
  function is_inf_nan;
    input [31:0] v;
    is_inf_nan = (v[`EXP_HI:`EXP_LO] == `EXP_MAX);
  endfunction
  // Opcode match shared by the three decoders
  function op_match;
    input [15:0] lo;
    input [15:0] hi;
    input [15:0] want_lo;
    input [15:0] hi_mask;
    op_match = (lo == want_lo) && ((hi & hi_mask) == 16'h0000);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire [2:0] fa = high_opcode_word[`FIELD_A_LO +: 3];
  wire [2:0] fb = high_opcode_word[`FIELD_B_LO +: 3];
  wire [2:0] fc = high_opcode_word[`FIELD_C_LO +: 3];
  wire [2:0] fd = high_opcode_word[`FIELD_D_LO +: 3];
  wire dec_iexp = issue_valid && op_match(low_opcode_word, high_opcode_word,
                                          `LOW_WORD_IEXP2, `HIGH_ZERO_MASK_1);
  wire dec_log  = issue_valid && op_match(low_opcode_word, high_opcode_word,
                                          `LOW_WORD_LOG2, `HIGH_ZERO_MASK_1);
  // Quadrant keeps two more source fields above
  wire dec_quad = issue_valid && op_match(low_opcode_word, high_opcode_word,
                                          `LOW_WORD_QUAD, `HIGH_ZERO_MASK_Q);
  wire [31:0] src_fp_reg = fp_result_reg[fb];
  wire [31:0] y_val = fp_result_reg[fc];
  wire [31:0] x_val = fp_result_reg[fd];
  ////////////////////////////////////////////////////////////////////////////
  // Inverse power-of-two: 2^-|x|, integer part into exponent, fraction linear below one and dropped from one up
  // Fraction part is a linear approximation; trades accuracy for area.
  reg [31:0] iexp_res;
  reg        iexp_uf;
  reg [7:0]  e;
  reg [31:0] ip;
  reg [23:0] m;
  always @* begin
    e = src_fp_reg[`EXP_HI:`EXP_LO];
    m = {1'b1, src_fp_reg[22:0]};
    ip = 32'h00000000;
    iexp_uf = 1'b0;
    iexp_res = `FP_ONE;
    if (is_inf_nan(src_fp_reg)) begin
      iexp_res = `FP_ZERO;
      iexp_uf = 1'b1;
    end else if (is_zero_or_den(src_fp_reg)) begin
      iexp_res = `FP_ONE;
    end else if (e >= 8'h86) begin
      iexp_res = `FP_ZERO;
      iexp_uf = 1'b1;
    end else if (e < `EXP_BIAS) begin
      iexp_res = {1'b0, 8'h7E, 23'h000000} |
                 {9'h000, ~(m[23:1] >> (8'h7E - e))};
    end else begin
      ip = {8'h00, m} >> (8'h96 - e);
      iexp_res = {1'b0, (`EXP_BIAS - ip[7:0]), 23'h000000};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Base-2 log: exponent as integer part, mantissa fraction linear
  reg [31:0] log_res;
  reg [8:0]  lg_int;
  reg [7:0]  lg_mag;
  reg [4:0]  lz;
  reg [30:0] lg_fix;
  reg [30:0] lg_sh;
  reg [7:0]  lg_exp;
  always @* begin
    lg_int = {1'b0, src_fp_reg[`EXP_HI:`EXP_LO]} - {1'b0, `EXP_BIAS};
    lg_mag = lg_int[8] ? (8'h00 - lg_int[7:0]) : lg_int[7:0];
    lg_fix = {lg_mag, src_fp_reg[22:0]};
    if (lg_int[8])
      lg_fix = {lg_mag, 23'h000000} - {8'h00, src_fp_reg[22:0]};
    lz = 5'h00;
    for (b = 0; b < 31; b = b + 1)
      if (lg_fix[b])
        lz = b[4:0];
    // Normalise so the leading one lands on the hidden bit
    if (lz >= 5'h17)
      lg_sh = lg_fix >> (lz - 5'h17);
    else
      lg_sh = lg_fix << (5'h17 - lz);
    lg_exp = 8'h7F + {3'h0, lz} - 8'h17;
    log_res = {lg_int[8], lg_exp, lg_sh[22:0]};
    if (src_fp_reg[`SIGN_BIT] || is_zero_or_den(src_fp_reg))
      log_res = `FP_NEG_INF;
    else if (is_inf_nan(src_fp_reg))
      log_res = `FP_POS_INF;
    else if (lg_fix == 31'h00000000)
      log_res = `FP_ZERO;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Quadrant and ratio
  reg [31:0] q_quad;
  reg [31:0] q_num;
  reg [31:0] q_den;
  reg [31:0] q_ratio;
  reg        q_of;
  reg        q_uf;
  always @* begin
    q_of = 1'b0;
    q_uf = 1'b0;
    if (y_val[30:0] <= x_val[30:0]) begin
      q_num = y_val;
      q_den = x_val;
      q_quad = `FP_ZERO;
    end else begin
      q_num = {~x_val[`SIGN_BIT], x_val[30:0]};
      q_den = y_val;
      q_quad = {y_val[`SIGN_BIT], QUARTER[30:0]};
    end
    // Negative X with |Y| no larger than |X| swings the angle to the half-turn quadrants
    if (x_val[`SIGN_BIT] && (y_val[30:0] <= x_val[30:0]))
      q_quad = {y_val[`SIGN_BIT], HALF[30:0]};
    // Ratio keeps sign and a coarse difference of the whole exponent and mantissa fields only
    q_ratio = {q_num[`SIGN_BIT] ^ q_den[`SIGN_BIT],
               q_num[30:0] - q_den[30:0] + {`EXP_BIAS, 23'h000000}};
    // NaN is taken as infinity throughout
    // division special cases
    if (is_zero_or_den(q_num) && is_zero_or_den(q_den)) begin
      q_ratio = `FP_ZERO;
      q_quad = `FP_ZERO;
      q_of = 1'b1;
    end else if (is_inf_nan(q_num) && is_inf_nan(q_den)) begin
      q_ratio = `FP_POS_INF;
      q_uf = 1'b1;
    end else if (is_inf_nan(q_num) || is_zero_or_den(q_den)) begin
      q_ratio = `FP_POS_INF;
      q_of = 1'b1;
    end else if (is_inf_nan(q_den)) begin
      q_ratio = `FP_ZERO;
      q_uf = 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Pipeline of five stages; single ops retire at stage four
  reg [31:0] p_res   [1:5];
  reg [31:0] p_res2  [1:5];
  reg [2:0]  p_dst   [1:5];
  reg [2:0]  p_dst2  [1:5];
  reg [3:0]  p_kind  [1:5];
  reg        p_of    [1:5];
  reg        p_uf    [1:5];
  // Retire strobes and flag set terms
  wire       ret4;
  wire       ret5;
  wire       next_uf_set;
  wire       next_of_set;
  assign ret4 = (p_kind[`LAT_SINGLE] == K_IEXP) || (p_kind[`LAT_SINGLE] == K_LOG);
  assign ret5 = (p_kind[`LAT_QUAD] == K_QUAD);
  assign next_uf_set = (ret4 & p_uf[`LAT_SINGLE]) | (ret5 & p_uf[`LAT_QUAD]);
  assign next_of_set = (ret4 & p_of[`LAT_SINGLE]) | (ret5 & p_of[`LAT_QUAD]);
  // Stage one captures the decoded op, its destinations and its results
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      for (j = 1; j <= 5; j = j + 1) begin
        p_kind[j] <= K_NONE;
        p_res[j]  <= `FP_ZERO;
        p_res2[j] <= `FP_ZERO;
        p_dst[j]  <= 3'h0;
        p_dst2[j] <= 3'h0;
        p_of[j]   <= 1'b0;
        p_uf[j]   <= 1'b0;
      end
    end else begin
      p_kind[1] <= dec_iexp ? K_IEXP : dec_log ? K_LOG : dec_quad ? K_QUAD : K_NONE;
      p_dst[1]  <= dec_quad ? fb : fa;
      p_dst2[1] <= fa;
      p_res[1]  <= dec_iexp ? iexp_res : dec_log ? log_res : q_ratio;
      p_res2[1] <= q_quad;
      p_uf[1]   <= (dec_iexp & iexp_uf) | (dec_quad & q_uf);
      p_of[1]   <= dec_quad & q_of;
      // Later stages only shift
      for (j = 2; j <= 5; j = j + 1) begin
        p_kind[j] <= p_kind[j-1];
        p_res[j]  <= p_res[j-1];
        p_res2[j] <= p_res2[j-1];
        p_dst[j]  <= p_dst[j-1];
        p_dst2[j] <= p_dst2[j-1];
        p_of[j]   <= p_of[j-1];
        p_uf[j]   <= p_uf[j-1];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Register file: loads first so a retire to the same index wins
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      // Reset clears all eight result words
      for (k = 0; k < 8; k = k + 1)
        fp_result_reg[k] <= `FP_ZERO;
    end else begin
      if (load_en)
        fp_result_reg[load_idx] <= load_data;
      if (ret4)
        fp_result_reg[p_dst[`LAT_SINGLE]] <= p_res[`LAT_SINGLE];
      if (ret5) begin
        fp_result_reg[p_dst[`LAT_QUAD]]  <= p_res[`LAT_QUAD];
        fp_result_reg[p_dst2[`LAT_QUAD]] <= p_res2[`LAT_QUAD];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Status pulses, read port and sticky flags
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      latched_underflow_flag <= 1'b0;
      latched_overflow_flag  <= 1'b0;
      test_flag              <= 1'b0;
      read_data              <= `FP_ZERO;
      op_recognised          <= 1'b0;
      write_done             <= 1'b0;
    end else begin
      op_recognised <= dec_iexp | dec_log | dec_quad;
      write_done    <= ret4 | ret5;
      // Read port shows the word as it stood before this edge's writes
      read_data     <= fp_result_reg[read_idx];
      // sticky flags, set wins over clear
      latched_underflow_flag <= (latched_underflow_flag & ~flag_clear) | next_uf_set;
      latched_overflow_flag  <= (latched_overflow_flag & ~flag_clear) | next_of_set;
    end
  end
endmodule // trig_math_type1_ops
`default_nettype wire

// ===== tb/trig_math_chk.sv
// Purpose: Port checker for the trig math Type 1 datapath
// Assumes: One clock, synchronous active-low reset
// Notes:   Latencies are counted from the issue edge
`timescale 1ns/1ps
`include "trig_math_map.vh"
`default_nettype none
module trig_math_chk (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Issue and flags
  input wire logic        issue_valid,
  input wire logic [15:0] low_opcode_word,
  input wire logic [15:0] high_opcode_word,
  input wire logic        flag_clear,
  input wire logic        latched_underflow_flag,
  input wire logic        latched_overflow_flag,
  input wire logic        test_flag,
  input wire logic        op_recognised,
  input wire logic        write_done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_single;
    issue_valid && (low_opcode_word == `LOW_WORD_IEXP2 || low_opcode_word == `LOW_WORD_LOG2)
      && (high_opcode_word & `HIGH_ZERO_MASK_1) == 16'h0000;
  endsequence
  sequence s_quad;
    issue_valid && low_opcode_word == `LOW_WORD_QUAD
      && (high_opcode_word & `HIGH_ZERO_MASK_Q) == 16'h0000;
  endsequence
  // Quadrant uses the upper fields, so only single ops may be refused here
  sequence s_dirty;
    issue_valid && high_opcode_word[6] && low_opcode_word != `LOW_WORD_QUAD;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_DECODE: assert property (s_single |=> op_recognised)
    else $error("decoded op not flagged");
  AST_BAD_HIGH: assert property (s_dirty |=> !op_recognised)
    else $error("op with dirty high word flagged");
  AST_QUAD_DECODE: assert property (s_quad |=> op_recognised)
    else $error("quadrant op not flagged");
  AST_IDLE_QUIET: assert property (!issue_valid |=> !op_recognised)
    else $error("recognised pulse without issue");
  AST_SINGLE_LAT: assert property (s_single |-> ##5 write_done)
    else $error("single-operand result late");
  AST_QUAD_LAT: assert property (s_quad |-> ##6 write_done)
    else $error("quadrant result late");
  AST_TEST_FLAG: assert property (!test_flag)
    else $error("test flag modified");
  AST_UF_STICKY: assert property (latched_underflow_flag && !flag_clear |=> latched_underflow_flag)
    else $error("underflow flag dropped");
  AST_OV_STICKY: assert property ($fell(latched_overflow_flag) |-> $past(flag_clear) || !$past(rst_n))
    else $error("overflow flag dropped");
endmodule // trig_math_chk
bind trig_math_type1_ops trig_math_chk u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .issue_valid(issue_valid),
  .low_opcode_word(low_opcode_word), .high_opcode_word(high_opcode_word),
  .flag_clear(flag_clear), .latched_underflow_flag(latched_underflow_flag),
  .latched_overflow_flag(latched_overflow_flag), .test_flag(test_flag),
  .op_recognised(op_recognised), .write_done(write_done));
`default_nettype wire

// ===== tb/cpu_issue_model.sv
// Purpose: CPU side model issuing ops, loading and reading registers
// Assumes: Drives only just after rising edges
// Notes:   idle waits out the result latency; put returns after one edge
`timescale 1ns/1ps
`default_nettype none
module cpu_issue_model (
  // Clock
  input  wire logic        clk_sys,
  // Issue, load and read
  output var  logic        issue_valid,
  output var  logic [15:0] low_opcode_word,
  output var  logic [15:0] high_opcode_word,
  output var  logic        load_en,
  output var  logic [2:0]  load_idx,
  output var  logic [31:0] load_data,
  output var  logic [2:0]  read_idx,
  output var  logic        flag_clear,
  input  wire logic [31:0] read_data
);
  initial begin
    {issue_valid, low_opcode_word, high_opcode_word, load_en} = '0;
    {load_idx, load_data, read_idx, flag_clear} = '0;
  end
  task automatic put(input logic [15:0] lo, input logic [15:0] hi);
    @(posedge clk_sys);
    issue_valid <= 1'h1;
    low_opcode_word <= lo;
    high_opcode_word <= hi;
  endtask
  task automatic idle();
    @(posedge clk_sys);
    issue_valid <= 1'h0;
    load_en <= 1'h0;
    flag_clear <= 1'h0;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic load(input logic [2:0] i, input logic [31:0] d);
    @(posedge clk_sys);
    load_en <= 1'h1;
    load_idx <= i;
    load_data <= d;
    idle();
  endtask
  task automatic clr();
    @(posedge clk_sys);
    flag_clear <= 1'h1;
    idle();
  endtask
  // Read data is registered, so two edges pass
  task automatic fetch(input logic [2:0] i, output logic [31:0] d);
    @(posedge clk_sys);
    read_idx <= i;
    repeat (2) @(posedge clk_sys);
    #1 d = read_data;
  endtask
endmodule // cpu_issue_model
`default_nettype wire

// ===== tb/tb_trig_math_type1_ops.sv
// Purpose: Self-checking bench for the trig math Type 1 datapath
// Assumes: CPU side model drives issue, loads and reads
// Notes:   Ratio values off the special cases are not judged
`timescale 1ns/1ps
`include "trig_math_map.vh"
`default_nettype none
module tb_trig_math_type1_ops;
  logic        clk_sys, rst_n, issue_valid, load_en, flag_clear, test_flag;
  logic        latched_underflow_flag, latched_overflow_flag, op_recognised, write_done;
  logic [15:0] low_opcode_word, high_opcode_word;
  logic [2:0]  load_idx, read_idx;
  logic [31:0] load_data, read_data, r, q;
  int          mismatches, total_checks;
  cpu_issue_model cpu (.clk_sys(clk_sys), .issue_valid(issue_valid),
    .low_opcode_word(low_opcode_word), .high_opcode_word(high_opcode_word),
    .load_en(load_en), .load_idx(load_idx), .load_data(load_data), .read_idx(read_idx),
    .flag_clear(flag_clear), .read_data(read_data));
  trig_math_type1_ops dut (.clk_sys(clk_sys), .rst_n(rst_n), .issue_valid(issue_valid),
    .low_opcode_word(low_opcode_word), .high_opcode_word(high_opcode_word),
    .load_en(load_en), .load_idx(load_idx), .load_data(load_data), .read_idx(read_idx),
    .read_data(read_data), .flag_clear(flag_clear), .test_flag(test_flag),
    .latched_underflow_flag(latched_underflow_flag), .write_done(write_done),
    .latched_overflow_flag(latched_overflow_flag), .op_recognised(op_recognised));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("ERROR %0t ns: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Source in register 1, result in register 2
  task automatic run1(input logic [15:0] lo, input logic [31:0] src);
    cpu.clr();
    cpu.load(3'h1, src);
    cpu.put(lo, 16'h000A);
    cpu.idle();
    cpu.fetch(3'h2, r);
  endtask
  task automatic t_iexp();
    logic [31:0] ins [6] = '{32'hC0000000, 32'h40000000, 32'h0, 32'h1, `FP_POS_INF, 32'h7FC00000};
    logic [31:0] outs [6] = '{`FP_QUARTER, `FP_QUARTER, `FP_ONE, `FP_ONE, 32'h0, 32'h0};
    for (int k = 0; k < 6; k++) begin
      run1(`LOW_WORD_IEXP2, ins[k]);
      check(r, outs[k]);
      check({31'h0, latched_overflow_flag}, 32'h0);
    end
  endtask
  task automatic t_log();
    logic [31:0] ins [7] = '{`FP_ONE, 32'h40000000, 32'hBF800000, 32'h0, 32'h1, `FP_POS_INF,
                             32'h7FC00000};
    logic [31:0] outs [7] = '{32'h0, `FP_ONE, `FP_NEG_INF, `FP_NEG_INF, `FP_NEG_INF,
                              `FP_POS_INF, `FP_POS_INF};
    for (int k = 0; k < 7; k++) begin
      run1(`LOW_WORD_LOG2, ins[k]);
      check(r, outs[k]);
    end
  endtask
  // Y in register 3, X in register 4
  task automatic t_quad();
    logic [31:0] ys [4] = '{32'h0, `FP_ONE, `FP_POS_INF, `FP_POS_INF};
    logic [31:0] xs [4] = '{32'h0, `FP_POS_INF, `FP_POS_INF, `FP_ONE};
    logic [31:0] ratio [4] = '{32'h0, 32'h0, `FP_POS_INF, 32'h0};
    logic [31:0] quad [4] = '{32'h0, 32'h0, 32'h0, `FP_QUARTER};
    logic [1:0]  flg [4] = '{2'h2, 2'h1, 2'h1, 2'h1};
    for (int k = 0; k < 4; k++) begin
      cpu.clr();
      cpu.load(3'h3, ys[k]);
      cpu.load(3'h4, xs[k]);
      cpu.put(`LOW_WORD_QUAD, 16'h08CA);
      cpu.idle();
      cpu.fetch(3'h1, r);
      cpu.fetch(3'h2, q);
      check(r, ratio[k]);
      check(q, quad[k]);
      check({30'h0, latched_overflow_flag, latched_underflow_flag}, {30'h0, flg[k]});
      check({31'h0, test_flag}, 32'h0);
    end
  endtask
  task automatic t_refuse();
    cpu.load(3'h2, 32'h12345678);
    cpu.put(`LOW_WORD_IEXP2, 16'h004A);
    cpu.put(16'hE277, 16'h000A);
    cpu.idle();
    cpu.fetch(3'h2, r);
    check(r, 32'h12345678);
  endtask
  task automatic t_b2b();
    cpu.load(3'h1, 32'h40000000);
    cpu.put(`LOW_WORD_IEXP2, 16'h000A);
    cpu.put(`LOW_WORD_LOG2, 16'h000B);
    cpu.idle();
    cpu.fetch(3'h2, r);
    check(r, `FP_QUARTER);
    cpu.fetch(3'h3, r);
    check(r, `FP_ONE);
  endtask
  task automatic t_sticky();
    run1(`LOW_WORD_IEXP2, `FP_POS_INF);
    check({31'h0, latched_underflow_flag}, 32'h1);
    cpu.load(3'h1, `FP_ONE);
    cpu.put(`LOW_WORD_LOG2, 16'h000A);
    cpu.idle();
    check({31'h0, latched_underflow_flag}, 32'h1);
    cpu.clr();
    check({31'h0, latched_underflow_flag}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    rst_n = 1'h0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'h1;
    t_iexp();
    t_log();
    t_quad();
    t_refuse();
    t_b2b();
    t_sticky();
    summarize();
  end
  // Run needs about 600 cycles; wide margin
  initial begin
    #400000;
    mismatches++;
    summarize();
  end
endmodule // tb_trig_math_type1_ops
`default_nettype wire
